// File: hdl/sipu_pkg.sv
// constants and carrier types of the script instruction prefetch unit
package sipu_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_CACHE_LINE = 8'h0c;
  localparam logic [7:0] ADR_DS_BASE = 8'h10;
  localparam logic [7:0] ADR_INS_PTR = 8'h2c;
  localparam logic [7:0] ADR_DMA_MODE = 8'h38;
  localparam logic [7:0] ADR_DMA_CTRL = 8'h3c;
  localparam logic [7:0] ADR_CMD_EN = 8'h40;
  localparam logic [7:0] ADR_STATUS = 8'h44;
  // dma_mode_control fields
  localparam int MODE_BURST_LSB = 6;
  localparam int MODE_OPFETCH_BIT = 1;
  // dma_control_register fields
  localparam int CTRL_PF_EN_BIT = 3;
  localparam int CTRL_PF_FLUSH_BIT = 5;
  // command enable fields
  localparam int CEN_READ_LINE_BIT = 0;
  localparam int CEN_READ_MULT_BIT = 1;
  localparam int CEN_WRITE_INV_BIT = 2;
  localparam int CEN_CACHE_MODE_BIT = 3;
  // reset values
  localparam logic [7:0] RST_DMA_MODE = 8'h00;
  localparam logic [7:0] RST_DMA_CTRL = 8'h00;
  localparam logic [7:0] RST_CACHE_LINE = 8'h00;
  localparam logic [3:0] RST_CMD_EN = 4'h0;
  // prefetch block sizes and opcode fetch burst in dwords
  localparam logic [4:0] PF_SMALL = 5'h04;
  localparam logic [4:0] PF_LARGE = 5'h08;
  localparam logic [4:0] OPFETCH_BURST = 5'h02;
  // bus commands
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_READ_MULT = 4'hc;
  localparam logic [3:0] CMD_READ_LINE = 4'he;
  localparam logic [3:0] CMD_WRITE_INV = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ISSUE = 3'h1,
    ST_RECV = 3'h3,
    ST_DELIVER = 3'h2,
    ST_LS_WAIT = 3'h6
  } sipu_state_t;

  typedef enum logic [1:0] {
    INS_PLAIN = 2'h0,
    INS_MEMCOPY = 2'h1,
    INS_INDIRECT = 2'h2,
    INS_TABLE_MOVE = 2'h3
  } sipu_ins_kind_t;

  typedef enum logic [2:0] {
    EV_MEMCOPY = 3'h0,
    EV_MEMCOPY_KEEP = 3'h1,
    EV_STORE = 3'h2,
    EV_STORE_KEEP = 3'h3,
    EV_XFER_TAKEN = 3'h4,
    EV_XFER_NOT = 3'h5
  } sipu_evt_kind_t;

  typedef struct packed {
    logic valid;
    sipu_ins_kind_t kind;
    logic [2:0] len;
  } sipu_fetch_t;

  typedef struct packed {
    logic valid;
    sipu_evt_kind_t kind;
    logic [31:0] target;
  } sipu_evt_t;

  typedef struct packed {
    logic valid;
    logic store;
    logic rel;
    logic [31:0] offset;
    logic [2:0] bytes;
  } sipu_ls_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [4:0] dwords;
    logic [3:0] first_be;
    logic [3:0] last_be;
  } sipu_bus_req_t;
endpackage

// File: hdl/sipu_prefetch.sv
// script instruction prefetch unit with bus request and register port
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module sipu_prefetch #(
  parameter int BUF_DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire sipu_pkg::sipu_fetch_t i_fetch,
  input wire sipu_pkg::sipu_evt_t i_evt,
  input wire sipu_pkg::sipu_ls_t i_ls,
  output logic o_busy,
  output logic o_ins_valid,
  output logic [31:0] o_ins_data,
  output logic o_ins_last,
  output sipu_pkg::sipu_bus_req_t o_bus,
  input wire logic i_bus_ack,
  input wire logic i_bus_rvalid,
  input wire logic [31:0] i_bus_rdata,
  input wire logic i_bus_end
);
  sipu_pkg::sipu_state_t state_q;
  logic [7:0] mode_q;
  logic pf_en_q;
  logic flush_bit_q;
  logic [7:0] cls_q;
  logic [3:0] cmd_en_q;
  logic [31:0] dsa_q;
  logic [31:0] ip_q;
  logic [31:0] mem_q [BUF_DEPTH];
  logic [31:0] base_q;
  logic [3:0] cnt_q;
  logic [2:0] wr_q;
  logic [2:0] off_q;
  logic [2:0] dly_q;
  logic [2:0] len_q;
  logic [2:0] got_q;
  sipu_pkg::sipu_ins_kind_t kind_q;
  logic use_pf_q;
  logic drop_q;
  logic misalign_q;
  logic [4:0] burst_dw;
  logic [4:0] limit_dw;
  logic [4:0] pf_size;
  logic pf_on;
  logic wr_ip;
  logic wr_ctrl_flush;
  logic flush_now;
  logic [31:0] diff;
  logic [3:0] hit_end;
  logic hit;
  logic [4:0] chunk_dw;
  logic [31:0] chunk_addr;
  logic [31:0] ls_addr;
  logic [3:0] ls_end;
  logic [3:0] first_be;
  logic [3:0] last_be;
  logic [31:0] status;
  logic [3:0] read_cmd;

  // burst code in mode register: 2, 4, 8 or 16 dwords
  // burst size decode
  assign burst_dw = 5'h02 << mode_q[sipu_pkg::MODE_BURST_LSB +: 2];

  always_comb
  begin
    limit_dw = burst_dw;
    if (cmd_en_q[sipu_pkg::CEN_CACHE_MODE_BIT] && (cls_q != 8'h00) && ({3'h0, cls_q} < 11'(burst_dw)))
    begin
      limit_dw = cls_q[4:0];
    end
  end

  always_comb
  begin
    if (limit_dw >= sipu_pkg::PF_LARGE)
      pf_size = sipu_pkg::PF_LARGE;
    else if (limit_dw >= sipu_pkg::PF_SMALL)
      pf_size = sipu_pkg::PF_SMALL;
    else
      pf_size = 5'h00;
  end

  assign pf_on = pf_en_q && (pf_size != 5'h00);

  assign wr_ip = i_reg_wr && (i_reg_addr == sipu_pkg::ADR_INS_PTR);
  assign wr_ctrl_flush = i_reg_wr && (i_reg_addr == sipu_pkg::ADR_DMA_CTRL)
    && i_reg_wdata[sipu_pkg::CTRL_PF_FLUSH_BIT];

  always_comb
  begin
    flush_now = wr_ip || wr_ctrl_flush || flush_bit_q;
    if (i_evt.valid)
    begin
      case (i_evt.kind)
        sipu_pkg::EV_MEMCOPY: flush_now = 1'b1;
        sipu_pkg::EV_STORE: flush_now = 1'b1;
        sipu_pkg::EV_XFER_TAKEN: flush_now = 1'b1;
        default: flush_now = flush_now;
      endcase
    end
  end

  assign diff = ip_q - base_q;
  assign hit_end = {1'b0, diff[4:2]} + {1'b0, i_fetch.len};
  assign hit = pf_on && (cnt_q != 4'h0) && (diff[31:5] == 27'h0) && (diff[1:0] == 2'h0)
    && (hit_end <= cnt_q);

  // chunk planning for the next bus ownership
  always_comb
  begin
    chunk_addr = ip_q + {27'h0, got_q, 2'h0};
    if (use_pf_q)
      chunk_dw = pf_size;
    else if (mode_q[sipu_pkg::MODE_OPFETCH_BIT] && (got_q == 3'h0))
      chunk_dw = (len_q >= 3'h2) ? sipu_pkg::OPFETCH_BURST : 5'h01;
    else if (mode_q[sipu_pkg::MODE_OPFETCH_BIT] && (kind_q == sipu_pkg::INS_TABLE_MOVE))
      chunk_dw = sipu_pkg::OPFETCH_BURST;
    else
      chunk_dw = 5'h01;
  end

  always_comb
  begin
    read_cmd = sipu_pkg::CMD_MEM_READ;
    if (cmd_en_q[sipu_pkg::CEN_CACHE_MODE_BIT] && (cls_q != 8'h00) && (chunk_dw > 5'h01))
    begin
      if (cmd_en_q[sipu_pkg::CEN_READ_MULT_BIT] && ({3'h0, chunk_dw} > cls_q))
        read_cmd = sipu_pkg::CMD_READ_MULT;
      else if (cmd_en_q[sipu_pkg::CEN_READ_LINE_BIT])
        read_cmd = sipu_pkg::CMD_READ_LINE;
    end
  end

  assign ls_addr = i_ls.rel ? (dsa_q + i_ls.offset) : i_ls.offset;
  // byte enables for odd start and end
  assign ls_end = {2'h0, ls_addr[1:0]} + {1'b0, i_ls.bytes} - 4'h1;
  always_comb
  begin
    first_be = 4'hf << ls_addr[1:0];
    last_be = 4'hf >> (2'h3 - ls_end[1:0]);
    if (ls_end[3:2] == 2'h0)
    begin
      first_be = first_be & last_be;
      last_be = first_be & last_be;
    end
  end

  assign status = {16'h0, misalign_q, drop_q, pf_on, pf_size[3:0], cnt_q, state_q, 2'h0};

  // register writes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      mode_q <= sipu_pkg::RST_DMA_MODE;
      pf_en_q <= sipu_pkg::RST_DMA_CTRL[sipu_pkg::CTRL_PF_EN_BIT];
      cls_q <= sipu_pkg::RST_CACHE_LINE;
      cmd_en_q <= sipu_pkg::RST_CMD_EN;
      dsa_q <= 32'h0;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        sipu_pkg::ADR_DMA_MODE: mode_q <= i_reg_wdata[7:0];
        sipu_pkg::ADR_DMA_CTRL: pf_en_q <= i_reg_wdata[sipu_pkg::CTRL_PF_EN_BIT];
        sipu_pkg::ADR_CACHE_LINE: cls_q <= i_reg_wdata[7:0];
        sipu_pkg::ADR_CMD_EN: cmd_en_q <= i_reg_wdata[3:0];
        sipu_pkg::ADR_DS_BASE: dsa_q <= i_reg_wdata;
        default: dsa_q <= dsa_q;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      flush_bit_q <= 1'b0;
    else
      flush_bit_q <= wr_ctrl_flush;
  end

  // register reads, data one cycle later
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_reg_rdata <= 32'h0;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        sipu_pkg::ADR_DMA_MODE: o_reg_rdata <= {24'h0, mode_q};
        sipu_pkg::ADR_DMA_CTRL: o_reg_rdata <= {26'h0, flush_bit_q, 1'b0, pf_en_q, 3'h0};
        sipu_pkg::ADR_CACHE_LINE: o_reg_rdata <= {24'h0, cls_q};
        sipu_pkg::ADR_CMD_EN: o_reg_rdata <= {28'h0, cmd_en_q};
        sipu_pkg::ADR_DS_BASE: o_reg_rdata <= dsa_q;
        sipu_pkg::ADR_INS_PTR: o_reg_rdata <= ip_q;
        sipu_pkg::ADR_STATUS: o_reg_rdata <= status;
        default: o_reg_rdata <= 32'h0;
      endcase
    end
    else
      o_reg_rdata <= 32'h0;
  end

  // instruction pointer: software write beats jump beats advance
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      ip_q <= 32'h0;
    else if (wr_ip)
      ip_q <= {i_reg_wdata[31:2], 2'h0};
    else if (i_evt.valid && (i_evt.kind == sipu_pkg::EV_XFER_TAKEN))
      ip_q <= {i_evt.target[31:2], 2'h0};
    else if ((state_q == sipu_pkg::ST_DELIVER) && (dly_q == len_q - 3'h1))
      ip_q <= ip_q + {27'h0, len_q, 2'h0};
  end

  // flush during a fetch is held until delivery ends
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      drop_q <= 1'b0;
    else if (flush_now && (state_q != sipu_pkg::ST_IDLE))
      drop_q <= 1'b1;
    else if (state_q == sipu_pkg::ST_IDLE)
      drop_q <= 1'b0;
  end

  // cache line misalignment flag of last fetch
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      misalign_q <= 1'b0;
    else if (state_q == sipu_pkg::ST_ISSUE && !o_bus.req)
      misalign_q <= (cls_q != 8'h00) && ((chunk_addr[9:2] & (cls_q - 8'h01)) != 8'h00);
  end

  // buffer storage; only written with bus read data
  always_ff @(posedge i_clk_sys)
  begin
    if ((state_q == sipu_pkg::ST_RECV) && i_bus_rvalid)
      mem_q[wr_q] <= i_bus_rdata;
  end

  // fetch sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      state_q <= sipu_pkg::ST_IDLE;
      base_q <= 32'h0;
      cnt_q <= 4'h0;
      wr_q <= 3'h0;
      off_q <= 3'h0;
      dly_q <= 3'h0;
      len_q <= 3'h1;
      got_q <= 3'h0;
      kind_q <= sipu_pkg::INS_PLAIN;
      use_pf_q <= 1'b0;
      o_bus <= '0;
      o_ins_valid <= 1'b0;
      o_ins_data <= 32'h0;
      o_ins_last <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_ins_valid <= 1'b0;
      o_ins_last <= 1'b0;
      case (state_q)
        sipu_pkg::ST_IDLE:
        begin
          if (flush_now)
          begin
            cnt_q <= 4'h0;
            o_busy <= 1'b0;
          end
          else if (i_fetch.valid && hit)
          begin
            kind_q <= i_fetch.kind;
            len_q <= i_fetch.len;
            off_q <= diff[4:2];
            dly_q <= 3'h0;
            use_pf_q <= 1'b1;
            o_busy <= 1'b1;
            state_q <= sipu_pkg::ST_DELIVER;
          end
          else if (i_fetch.valid)
          begin
            kind_q <= i_fetch.kind;
            len_q <= i_fetch.len;
            use_pf_q <= pf_on;
            base_q <= ip_q;
            cnt_q <= 4'h0;
            got_q <= 3'h0;
            wr_q <= 3'h0;
            off_q <= 3'h0;
            o_busy <= 1'b1;
            state_q <= sipu_pkg::ST_ISSUE;
          end
          else if (i_ls.valid)
          begin
            o_bus.req <= 1'b1;
            o_bus.write <= i_ls.store;
            o_bus.addr <= {ls_addr[31:2], 2'h0};
            o_bus.dwords <= (ls_end[3:2] == 2'h0) ? 5'h01 : 5'h02;
            o_bus.first_be <= first_be;
            o_bus.last_be <= last_be;
            o_bus.cmd <= i_ls.store ? sipu_pkg::CMD_MEM_WRITE : sipu_pkg::CMD_MEM_READ;
            // write and invalidate only on a full aligned line
            if (i_ls.store && cmd_en_q[sipu_pkg::CEN_WRITE_INV_BIT]
              && cmd_en_q[sipu_pkg::CEN_CACHE_MODE_BIT] && (cls_q == 8'h01)
              && (ls_addr[1:0] == 2'h0) && (i_ls.bytes == 3'h4))
              o_bus.cmd <= sipu_pkg::CMD_WRITE_INV;
            o_busy <= 1'b1;
            state_q <= sipu_pkg::ST_LS_WAIT;
          end
          else
            o_busy <= 1'b0;
        end
        sipu_pkg::ST_ISSUE:
        begin
          if (!o_bus.req)
          begin
            o_bus.req <= 1'b1;
            o_bus.write <= 1'b0;
            o_bus.cmd <= read_cmd;
            o_bus.addr <= chunk_addr;
            o_bus.dwords <= chunk_dw;
            o_bus.first_be <= 4'hf;
            o_bus.last_be <= 4'hf;
            wr_q <= got_q;
          end
          else if (i_bus_ack)
          begin
            o_bus.req <= 1'b0;
            state_q <= sipu_pkg::ST_RECV;
          end
        end
        sipu_pkg::ST_RECV:
        begin
          if (i_bus_rvalid)
          begin
            wr_q <= wr_q + 3'h1;
            cnt_q <= {1'b0, wr_q} + 4'h1;
          end
          if (i_bus_end)
          begin
            if (!use_pf_q && (got_q + o_bus.dwords[2:0] < len_q))
            begin
              got_q <= got_q + o_bus.dwords[2:0];
              state_q <= sipu_pkg::ST_ISSUE;
            end
            else
            begin
              dly_q <= 3'h0;
              state_q <= sipu_pkg::ST_DELIVER;
            end
          end
        end
        sipu_pkg::ST_DELIVER:
        begin
          o_ins_valid <= 1'b1;
          o_ins_data <= mem_q[off_q + dly_q];
          dly_q <= dly_q + 3'h1;
          if (dly_q == len_q - 3'h1)
          begin
            o_ins_last <= 1'b1;
            // buffer kept only while prefetching and unflushed
            if (drop_q || flush_now || !use_pf_q || !pf_on)
              cnt_q <= 4'h0;
            o_busy <= 1'b0;
            state_q <= sipu_pkg::ST_IDLE;
          end
        end
        sipu_pkg::ST_LS_WAIT:
        begin
          if (o_bus.req && i_bus_ack)
            o_bus.req <= 1'b0;
          if (!o_bus.req && i_bus_end)
          begin
            if (drop_q || flush_now)
              cnt_q <= 4'h0;
            o_busy <= 1'b0;
            state_q <= sipu_pkg::ST_IDLE;
          end
        end
        default:
        begin
          o_bus.req <= 1'b0;
          state_q <= sipu_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule // sipu_prefetch

// File: tb/sipu_prefetch_sva.sv
// assertion checker for the script instruction prefetch unit
`timescale 1ns/10ps
module sipu_prefetch_sva (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire sipu_pkg::sipu_fetch_t i_fetch,
  input wire logic o_busy,
  input wire logic o_ins_valid,
  input wire logic o_ins_last,
  input wire sipu_pkg::sipu_bus_req_t o_bus,
  input wire logic i_bus_ack
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] mode_q, ctl_q, cl_q, bl, lim;
  logic [3:0] cen_q;
  logic [4:0] sz, exp_q;
  logic [1:0] kind_q;
  logic first_q, op_q, take, pf;
  assign take = i_fetch.valid && !o_busy;
  assign bl = 8'h02 << mode_q[7:6];
  assign lim = (cen_q[3] && cl_q != 8'h00 && cl_q < bl) ? cl_q : bl;
  assign sz = (lim >= 8'h08) ? 5'h08 : ((lim >= 8'h04) ? 5'h04 : 5'h00);
  assign pf = ctl_q[3] && sz != 5'h00;
  // shadow of the mode registers, seen from the write port
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      mode_q <= sipu_pkg::RST_DMA_MODE;
      ctl_q <= sipu_pkg::RST_DMA_CTRL;
      cl_q <= sipu_pkg::RST_CACHE_LINE;
      cen_q <= sipu_pkg::RST_CMD_EN;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == sipu_pkg::ADR_DMA_MODE)
        mode_q <= i_reg_wdata[7:0];
      if (i_reg_addr == sipu_pkg::ADR_DMA_CTRL)
        ctl_q <= i_reg_wdata[7:0];
      if (i_reg_addr == sipu_pkg::ADR_CACHE_LINE)
        cl_q <= i_reg_wdata[7:0];
      if (i_reg_addr == sipu_pkg::ADR_CMD_EN)
        cen_q <= i_reg_wdata[3:0];
    end
  end
  // first ownership of a fetch, expected size fixed at take
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || o_ins_last)
    begin
      first_q <= 1'b0;
      op_q <= 1'b0;
    end
    else if (take)
    begin
      first_q <= 1'b1;
      op_q <= !pf && mode_q[sipu_pkg::MODE_OPFETCH_BIT];
      exp_q <= pf ? sz : (mode_q[sipu_pkg::MODE_OPFETCH_BIT] ? 5'h02 : 5'h01);
      kind_q <= i_fetch.kind;
    end
    else if (o_bus.req && i_bus_ack)
      first_q <= 1'b0;
  end
  sequence s_flush_wr;
    i_reg_wr && i_reg_addr == sipu_pkg::ADR_DMA_CTRL && i_reg_wdata[5];
  endsequence
  sequence s_ctl_rd;
    i_reg_rd && i_reg_addr == sipu_pkg::ADR_DMA_CTRL;
  endsequence
  property p_flush_clear;
    s_flush_wr ##2 s_ctl_rd |=> !o_reg_rdata[sipu_pkg::CTRL_PF_FLUSH_BIT];
  endproperty
  a_flush_clear: assert property (p_flush_clear)
    else $error("flush bit did not clear");
  property p_rd_idle;
    !i_reg_rd |=> o_reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");
  property p_req_hold;
    o_bus.req && !i_bus_ack |=> o_bus.req && $stable(o_bus);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("bus request changed before ack");
  property p_ack_drop;
    o_bus.req && i_bus_ack |=> !o_bus.req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("bus request kept after ack");
  property p_sizes;
    o_bus.req |-> o_bus.dwords inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  endproperty
  a_sizes: assert property (p_sizes)
    else $error("illegal burst length");
  property p_cmd_gate;
    o_bus.req |-> (o_bus.cmd != sipu_pkg::CMD_READ_LINE || cen_q[0])
      && (o_bus.cmd != sipu_pkg::CMD_READ_MULT || cen_q[1])
      && (o_bus.cmd != sipu_pkg::CMD_WRITE_INV || cen_q[2]);
  endproperty
  a_cmd_gate: assert property (p_cmd_gate)
    else $error("disabled bus command used");
  property p_first_len;
    o_bus.req && first_q |-> o_bus.dwords == exp_q;
  endproperty
  a_first_len: assert property (p_first_len)
    else $error("wrong first fetch burst length");
  property p_op_rest;
    o_bus.req && !first_q && op_q |-> o_bus.dwords == ((kind_q == 2'h3) ? 5'h02 : 5'h01);
  endproperty
  a_op_rest: assert property (p_op_rest)
    else $error("wrong opcode remainder length");
  property p_valid_run;
    o_ins_valid && !o_ins_last |=> o_ins_valid;
  endproperty
  a_valid_run: assert property (p_valid_run)
    else $error("gap in instruction delivery");
endmodule // sipu_prefetch_sva

bind sipu_prefetch sipu_prefetch_sva i_sva (.i_clk_sys, .i_sys_rst, .i_reg_addr, .i_reg_wdata,
  .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_fetch, .o_busy, .o_ins_valid, .o_ins_last, .o_bus,
  .i_bus_ack);

// File: tb/sipu_mem_model.sv
// behavioural host memory target; each dword reads as its own address
`timescale 1ns/10ps
module sipu_mem_model (
  input wire logic i_clk_sys,
  input wire sipu_pkg::sipu_bus_req_t i_bus,
  input wire logic [3:0] i_wait,
  output logic o_ack,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic o_end
);
  logic [31:0] a;
  logic [4:0] n;
  logic w;
  initial
  begin
    o_ack = 1'b0;
    o_rvalid = 1'b0;
    o_rdata = 32'h0;
    o_end = 1'b0;
    forever
    begin
      @(posedge i_clk_sys);
      if (i_bus.req === 1'b1)
      begin
        repeat (i_wait) @(posedge i_clk_sys);
        a = i_bus.addr;
        n = i_bus.dwords;
        w = i_bus.write;
        o_ack <= 1'b1;
        @(posedge i_clk_sys);
        o_ack <= 1'b0;
        for (int k = 0; k < n && !w; k++)
        begin
          o_rvalid <= 1'b1;
          o_rdata <= a + 32'(4 * k);
          @(posedge i_clk_sys);
        end
        // released data line shows no stale value
        o_rvalid <= 1'b0;
        o_rdata <= ~o_rdata;
        o_end <= 1'b1;
        @(posedge i_clk_sys);
        o_end <= 1'b0;
      end
    end
  end
endmodule // sipu_mem_model

// File: tb/tb_top.sv
// self-checking testbench for the script instruction prefetch unit
`timescale 1ns/10ps
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] o_reg_rdata, o_ins_data, i_bus_rdata;
  sipu_pkg::sipu_fetch_t i_fetch = '0;
  sipu_pkg::sipu_evt_t i_evt = '0;
  sipu_pkg::sipu_ls_t i_ls = '0;
  sipu_pkg::sipu_bus_req_t o_bus, lb;
  logic o_busy, o_ins_valid, o_ins_last, i_bus_ack, i_bus_rvalid, i_bus_end;
  logic [3:0] slow = 4'h0;
  logic [31:0] eip = 32'h0;
  logic [31:0] got[$];
  logic [7:0] md[5] = '{8'h80, 8'h40, 8'hc0, 8'hc0, 8'h00};
  logic [3:0] cen[5] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h0};
  logic [4:0] psz[5] = '{5'h08, 5'h04, 5'h08, 5'h04, 5'h01};
  int errors = 0;
  int checks_done = 0;
  int own = 0;
  int cyc = 0;
  int o0;
  always #20 i_clk_sys = ~i_clk_sys;
  sipu_prefetch i_sipu_prefetch (.i_clk_sys, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_fetch, .i_evt, .i_ls, .o_busy, .o_ins_valid, .o_ins_data,
    .o_ins_last, .o_bus, .i_bus_ack, .i_bus_rvalid, .i_bus_rdata, .i_bus_end);
  sipu_mem_model i_sipu_mem_model (.i_clk_sys, .i_bus(o_bus), .i_wait(slow), .o_ack(i_bus_ack),
    .o_rvalid(i_bus_rvalid), .o_rdata(i_bus_rdata), .o_end(i_bus_end));
  // ownership log, delivered dwords, hang guard
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (o_bus.req === 1'b1 && i_bus_ack === 1'b1)
    begin
      own++;
      lb = o_bus;
    end
    if (o_ins_valid === 1'b1)
      got.push_back(o_ins_data);
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, e);
  endtask
  task automatic idle();
    o0 = own;
    @(posedge i_clk_sys);
    while (o_busy !== 1'b0)
      @(posedge i_clk_sys);
  endtask
  task automatic evt(input logic [2:0] k, input logic [31:0] t);
    idle();
    i_evt <= '{1'b1, sipu_pkg::sipu_evt_kind_t'(k), t};
    @(posedge i_clk_sys);
    i_evt.valid <= 1'b0;
  endtask
  // eo: ownerships expected, ed: length of the last one
  task automatic fetch(input logic [1:0] k, input logic [2:0] n, input int eo,
    input logic [4:0] ed);
    int w;
    got.delete();
    idle();
    i_fetch <= '{1'b1, sipu_pkg::sipu_ins_kind_t'(k), n};
    @(posedge i_clk_sys);
    i_fetch.valid <= 1'b0;
    w = 0;
    while (got.size() < n && w < 300)
    begin
      @(posedge i_clk_sys);
      w++;
    end
    for (int i = 0; i < n; i++)
      chk(got[i], eip + 32'(4 * i));
    chk(32'(own - o0), 32'(eo));
    if (eo > 0)
      chk(32'(lb.dwords), 32'(ed));
    eip = eip + 32'(4 * n);
  endtask
  task automatic ls(input logic s, input logic r, input logic [31:0] off, input logic [2:0] b);
    idle();
    i_ls <= '{1'b1, s, r, off, b};
    @(posedge i_clk_sys);
    i_ls.valid <= 1'b0;
    while (own == o0)
      @(posedge i_clk_sys);
  endtask
  initial
  begin
    repeat (8) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(sipu_pkg::ADR_DMA_MODE, 32'(sipu_pkg::RST_DMA_MODE));
    rd(sipu_pkg::ADR_DMA_CTRL, 32'(sipu_pkg::RST_DMA_CTRL));
    rd(8'h50, 32'h0);
    wr(sipu_pkg::ADR_DMA_MODE, 32'hc2);
    rd(sipu_pkg::ADR_DMA_MODE, 32'hc2);
    wr(sipu_pkg::ADR_CACHE_LINE, 32'h1ff);
    rd(sipu_pkg::ADR_CACHE_LINE, 32'hff);
    wr(sipu_pkg::ADR_CMD_EN, 32'h1f);
    rd(sipu_pkg::ADR_CMD_EN, 32'hf);
    wr(sipu_pkg::ADR_CMD_EN, 32'h0);
    wr(sipu_pkg::ADR_DMA_MODE, 32'h0);
    fetch(2'h0, 3'h2, 2, 5'h01);
    wr(sipu_pkg::ADR_DMA_MODE, 32'h02);
    slow = 4'h3;
    fetch(2'h0, 3'h2, 1, 5'h02);
    fetch(2'h1, 3'h3, 2, 5'h01);
    fetch(2'h2, 3'h3, 2, 5'h01);
    fetch(2'h3, 3'h4, 2, 5'h02);
    slow = 4'h0;
    wr(sipu_pkg::ADR_DMA_MODE, 32'h80);
    wr(sipu_pkg::ADR_DMA_CTRL, 32'h08);
    for (int i = 0; i < 5; i++)
    begin
      wr(sipu_pkg::ADR_CMD_EN, 32'(cen[i]));
      wr(sipu_pkg::ADR_CACHE_LINE, 32'h4);
      wr(sipu_pkg::ADR_DMA_MODE, 32'(md[i]));
      eip = 32'h300 + 32'(64 * i);
      wr(sipu_pkg::ADR_INS_PTR, eip);
      fetch(2'h0, 3'h1, 1, psz[i]);
      if (cen[i] == 4'h0)
        chk(32'(lb.cmd), 32'(sipu_pkg::CMD_MEM_READ));
      else
        chk(32'(lb.cmd), 32'(sipu_pkg::CMD_READ_LINE));
    end
    wr(sipu_pkg::ADR_DMA_MODE, 32'h80);
    eip = 32'h400;
    wr(sipu_pkg::ADR_INS_PTR, eip);
    fetch(2'h0, 3'h2, 1, 5'h08);
    fetch(2'h0, 3'h2, 0, 5'h00);
    for (int i = 0; i < 6; i++)
    begin
      evt(3'(i), 32'h600);
      if (i == 4)
        eip = 32'h600;
      fetch(2'h0, 3'h1, (i % 2 == 0) ? 1 : 0, 5'h08);
    end
    wr(sipu_pkg::ADR_INS_PTR, 32'h803);
    rd(sipu_pkg::ADR_INS_PTR, 32'h800);
    eip = 32'h800;
    fetch(2'h0, 3'h1, 1, 5'h08);
    wr(sipu_pkg::ADR_DMA_CTRL, 32'h28);
    rd(sipu_pkg::ADR_DMA_CTRL, 32'h08);
    fetch(2'h0, 3'h1, 1, 5'h08);
    wr(sipu_pkg::ADR_DS_BASE, 32'h1000);
    rd(sipu_pkg::ADR_DS_BASE, 32'h1000);
    ls(1'b0, 1'b1, 32'h20, 3'h4);
    chk(lb.addr, 32'h1020);
    ls(1'b1, 1'b0, 32'h41, 3'h2);
    chk({lb.addr[23:0], lb.cmd, lb.first_be}, {24'h40, sipu_pkg::CMD_MEM_WRITE, 4'h6});
    idle();
    wrap_up();
  end
endmodule // tb_top
